// File: fbm_core.sv
// Purpose: Radix 4/2 butterfly, bypass and complex accumulate datapath.
// Assumes: External RAM banks read combinationally within the cycle.
// Notes: Internal sums are one's complement fixed point words.
`timescale 1ns/10ps
`include "fbm_defs.svh"

// Function
// - Data words are 7,7,4 packed floats.
// - Mantissas are sign magnitude, point left.
// - Exponent 0..12 means two to minus.
// - Exponent adjust lowers exponent by 0..3.
// - Stage 0 twiddle is a 5,0,4 window.
// - Stages 1..5 twiddle is 5,5,0.
// - Accumulate operands use 4 bit mantissas.
// - Accumulator is 15,15,6 over 36 bits.
// - Radix 4 butterfly over four serial points.
// - Normal or auxiliary input, chosen by aux_sel, with twiddle.
// - One point in, one point out.
// - Sign magnitude data words outside, one's complement inside and in accumulator words.
// - Two 512 by 18 banks, double buffered.
// - Radix 2 butterfly on two points.
// - Bypass passes points unaltered.
// - Accumulate multiplies, adds RAM sum, writes back.
// - Non-polarization takes one pair per two clocks.
// - Polarization adds two products per sum.
// - At most one access per RAM bank per clock.
// - Oscillator phase and increment load serially.
// - Oscillator carry registered, accumulator enabled.
// - Store saves phase, rewind restores it.
// - Both enable pins high select accumulate.
module fbm_core
    import fbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire fbm_mode_t fft_mode,
    input wire logic pol_mode,
    input wire logic stage0,
    input wire logic [1:0] exp_adj,
    input wire logic aux_sel,
    input wire logic [`FBM_D_W-1:0] data_in,
    input wire logic [`FBM_D_W-1:0] aux_in,
    input wire logic [9:0] twid_in,
    input wire logic osc_sine_in_pin,
    input wire logic osc_cosine_in_pin,
    input wire logic osc_output_enable_pin,
    input wire logic coeff_output_enable_pin,
    input wire logic ext_addr_sel,
    input wire logic [`FBM_RAM_AW-1:0] ext_wr_addr,
    input wire logic [`FBM_RAM_AW-1:0] ext_rd_addr,
    input wire logic acc_clear,
    output logic [`FBM_RAM_AW-1:0] ram_a_addr,
    output logic ram_a_we,
    output logic [`FBM_D_W-1:0] ram_a_wdata,
    input wire logic [`FBM_D_W-1:0] ram_a_rdata,
    output logic [`FBM_RAM_AW-1:0] ram_b_addr,
    output logic ram_b_we,
    output logic [`FBM_D_W-1:0] ram_b_wdata,
    input wire logic [`FBM_D_W-1:0] ram_b_rdata,
    output logic [`FBM_D_W-1:0] data_out,
    output logic data_valid_out,
    input wire logic osc_ser_in,
    input wire logic osc_shift,
    input wire logic osc_load,
    input wire logic osc_clk_en,
    input wire logic osc_store,
    input wire logic osc_rewind,
    input wire logic osc_carry_in,
    output logic [`FBM_OSC_W-1:0] osc_phase,
    output logic osc_carry_out,
    output logic osc_ser_out
);

    typedef struct packed {
        logic [`FBM_RAM_AW-1:0] addr;
        logic bank;
        logic filled;
        logic rd_pend;
        logic rd_sel;
        logic [1:0] gcnt;
        logic [1:0] ocnt;
        logic hold_ok;
        logic [3:0][31:0] g_re;
        logic [3:0][31:0] g_im;
        logic [3:0][31:0] h_re;
        logic [3:0][31:0] h_im;
        logic [`FBM_RAM_AW-1:0] a_addr;
        logic a_we;
        logic [`FBM_D_W-1:0] a_wd;
        logic [`FBM_RAM_AW-1:0] b_addr;
        logic b_we;
        logic [`FBM_D_W-1:0] b_wd;
        logic [`FBM_D_W-1:0] dout;
        logic dval;
        fbm_ph_t ph;
        logic [63:0] prod;
        logic [`FBM_RAM_AW-1:0] mac_cnt;
    } fbm_st_t;

    fbm_st_t st_reg;
    fbm_st_t st_next;
    logic mac;
    fbm_mode_t mode;

    function automatic logic [31:0] fbm_mag(input logic [31:0] v);
        return v[31] ? ~v : v;
    endfunction : fbm_mag

    function automatic logic [31:0] fbm_oc(input logic s,
                                          input logic [31:0] m);
        return s ? ~m : m;
    endfunction : fbm_oc

    function automatic logic [31:0] fbm_add(input logic [31:0] a,
                                           input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[31:0] + {31'h0, s[32]};
    endfunction : fbm_add

    function automatic logic [31:0] fbm_rmul(input logic [31:0] x,
        input logic s, input logic [3:0] m, input logic [3:0] e);
        logic [35:0] p;
        p = {4'h0, fbm_mag(x)} * {32'h0, m};
        p = p >> (4 + e);
        return fbm_oc(s ^ x[31], p[31:0]);
    endfunction : fbm_rmul

    function automatic logic [63:0] fbm_cmul(input logic [63:0] x,
        input logic [9:0] t, input logic [3:0] e);
        logic [31:0] re;
        logic [31:0] im;
        re = fbm_add(fbm_rmul(x[63:32], t[4], t[3:0], e),
                     ~fbm_rmul(x[31:0], t[9], t[8:5], e));
        im = fbm_add(fbm_rmul(x[63:32], t[9], t[8:5], e),
                     fbm_rmul(x[31:0], t[4], t[3:0], e));
        return {re, im};
    endfunction : fbm_cmul

    // field split, point left, scale, adjust
    function automatic logic [63:0] fbm_unpack(
        input logic [`FBM_D_W-1:0] d, input logic [1:0] adj,
        input logic trunc);
        logic [3:0] e;
        logic [5:0] mr;
        logic [5:0] mi;
        e = d[`FBM_D_EX_LSB +: 4];
        if (e > 4'(`FBM_EXP_MAX))
            e = 4'(`FBM_EXP_MAX);
        e = (e > {2'b00, adj}) ? e - {2'b00, adj} : 4'h0;
        mr = d[`FBM_D_RE_LSB +: 6];
        mi = d[`FBM_D_IM_LSB +: 6];
        if (trunc)
        begin
            mr = mr & `FBM_TRUNC_MASK;
            mi = mi & `FBM_TRUNC_MASK;
        end
        return {fbm_oc(d[`FBM_D_RE_LSB+6], {26'h0, mr} << (`FBM_D_SH - e)),
                fbm_oc(d[`FBM_D_IM_LSB+6], {26'h0, mi} << (`FBM_D_SH - e))};
    endfunction : fbm_unpack

    function automatic logic [`FBM_D_W-1:0] fbm_pack(input logic [63:0] x);
        logic [31:0] mr;
        logic [31:0] mi;
        logic [31:0] mx;
        logic [3:0] e;
        mr = fbm_mag(x[63:32]);
        mi = fbm_mag(x[31:0]);
        mx = (mr > mi) ? mr : mi;
        e = 4'h0;
        for (int i = 0; i <= `FBM_EXP_MAX; i++)
            if (mx < (32'h1 << (`FBM_FB - i)))
                e = 4'(i);
        mr = mr >> (`FBM_D_SH - e);
        mi = mi >> (`FBM_D_SH - e);
        if (mr > 32'd63)
            mr = 32'd63;
        if (mi > 32'd63)
            mi = 32'd63;
        return {e, x[31], mi[5:0], x[63], mr[5:0]};
    endfunction : fbm_pack

    function automatic logic [31:0] fbm_acc_part(input logic [14:0] m,
                                                input logic [5:0] ex);
        logic [4:0] sh;
        logic [31:0] mg;
        if ($signed(ex) < -$signed(6'(`FBM_A_SH)))
            sh = 5'd0;
        else if ($signed(ex) > 6'sd8)
            sh = 5'(`FBM_A_SH_MAX);
        else
            sh = 5'(ex + 6'(`FBM_A_SH));
        mg = {18'h0, m[14] ? ~m[13:0] : m[13:0]};
        return fbm_oc(m[14], mg << sh);
    endfunction : fbm_acc_part

    function automatic logic [`FBM_A_W-1:0] fbm_acc_pack(
        input logic [63:0] x);
        logic [31:0] mr;
        logic [31:0] mi;
        logic [31:0] mx;
        logic [4:0] sh;
        mr = fbm_mag(x[63:32]);
        mi = fbm_mag(x[31:0]);
        mx = (mr > mi) ? mr : mi;
        sh = 5'(`FBM_A_SH_MAX);
        for (int i = `FBM_A_SH_MAX; i >= 0; i--)
            if (mx < (32'h1 << (14 + i)))
                sh = 5'(i);
        mr = mr >> sh;
        mi = mi >> sh;
        if (mr > {18'h0, `FBM_A_MAG_MAX})
            mr = {18'h0, `FBM_A_MAG_MAX};
        if (mi > {18'h0, `FBM_A_MAG_MAX})
            mi = {18'h0, `FBM_A_MAG_MAX};
        return {6'({1'b0, sh} - 6'(`FBM_A_SH)),
                15'(fbm_oc(x[31], mi)), 15'(fbm_oc(x[63], mr))};
    endfunction : fbm_acc_pack

    function automatic logic [63:0] fbm_rot(input logic [63:0] x,
                                           input logic [1:0] m);
        case (m)
            2'd0: return x;
            2'd1: return {x[31:0], ~x[63:32]};
            2'd2: return {~x[63:32], ~x[31:0]};
            default: return {~x[31:0], x[63:32]};
        endcase
    endfunction : fbm_rot

    // accumulate selected by both enable pins
    assign mac = osc_output_enable_pin & coeff_output_enable_pin;

    always_comb
    begin
        if (mac)
            mode = pol_mode ? FBM_MACPOL : FBM_MACNP;
        else if (fft_mode == FBM_R2 || fft_mode == FBM_BYP)
            mode = fft_mode;
        else
            mode = FBM_R4;
    end

    always_comb
    begin
        logic [`FBM_D_W-1:0] pin;
        logic [`FBM_D_W-1:0] rd_word;
        logic [9:0] tw;
        logic [3:0] te;
        logic [63:0] pt;
        logic [63:0] sum;
        logic [63:0] acc;
        logic [`FBM_A_W-1:0] aw;
        logic [`FBM_RAM_AW-1:0] waddr;
        logic [`FBM_RAM_AW-1:0] raddr;
        logic [1:0] last;
        pin = '0;
        rd_word = '0;
        tw = '0;
        te = '0;
        pt = '0;
        sum = '0;
        acc = '0;
        aw = '0;
        waddr = '0;
        raddr = '0;
        last = '0;
        st_next = st_reg;
        st_next.dval = 1'b0;
        // port choice; twiddle sampled on the same edge
        pin = aux_sel ? aux_in : data_in;
        if (mac)
        begin
            // 4,4,4 operand from twiddle bits and two pins
            tw = {twid_in[7], twid_in[6:4], 1'b0,
                  twid_in[3], twid_in[2:0], 1'b0};
            te = {osc_cosine_in_pin, osc_sine_in_pin, twid_in[9:8]};
        end
        else if (stage0)
        begin
            // real window with its own exponent
            tw = {5'h00, twid_in[4:0]};
            te = twid_in[8:5];
        end
        else
        begin
            // sine and cosine on all ten bits
            tw = twid_in;
            te = 4'h0;
        end
        waddr = ext_addr_sel ? ext_wr_addr : st_reg.addr;
        raddr = ext_addr_sel ? ext_rd_addr : st_reg.addr;
        rd_word = st_reg.rd_sel ? ram_a_rdata : ram_b_rdata;
        last = (mode == FBM_R4) ? 2'd3 : 2'd1;
        if (mac)
        begin
            st_next.rd_pend = 1'b0;
            st_next.hold_ok = 1'b0;
            st_next.gcnt = 2'd0;
            pt = fbm_cmul(fbm_unpack(pin, exp_adj, 1'b1), tw, te);
            case (st_reg.ph)
                FBM_PH_OPER:
                begin
                    // operand pair taken, sum read next
                    st_next.prod = pt;
                    st_next.a_addr = ext_addr_sel ? ext_wr_addr
                                                  : st_reg.mac_cnt;
                    st_next.b_addr = st_next.a_addr;
                    st_next.a_we = 1'b0;
                    st_next.b_we = 1'b0;
                    st_next.mac_cnt = st_reg.mac_cnt + 9'h1;
                    st_next.ph = FBM_PH_SUM;
                end
                FBM_PH_SUM:
                begin
                    // stored sum is 15,15,6 across both banks
                    aw = {ram_b_rdata, ram_a_rdata};
                    acc = {fbm_acc_part(aw[`FBM_A_RE_LSB +: 15],
                                        aw[`FBM_A_EX_LSB +: 6]),
                           fbm_acc_part(aw[`FBM_A_IM_LSB +: 15],
                                        aw[`FBM_A_EX_LSB +: 6])};
                    if (acc_clear)
                        acc = '0;
                    // product added to the RAM sum
                    sum = {fbm_add(acc[63:32], st_reg.prod[63:32]),
                           fbm_add(acc[31:0], st_reg.prod[31:0])};
                    // second product joins the same sum
                    if (mode == FBM_MACPOL)
                        sum = {fbm_add(sum[63:32], pt[63:32]),
                               fbm_add(sum[31:0], pt[31:0])};
                    aw = fbm_acc_pack(sum);
                    st_next.a_wd = aw[`FBM_D_W-1:0];
                    st_next.b_wd = aw[`FBM_A_W-1:`FBM_D_W];
                    st_next.a_we = 1'b1;
                    st_next.b_we = 1'b1;
                    st_next.ph = FBM_PH_OPER;
                end
                default:
                begin
                    st_next.ph = FBM_PH_OPER;
                end
            endcase
        end
        else
        begin
            st_next.ph = FBM_PH_OPER;
            // one bank written while the other is read
            st_next.a_we = ~st_reg.bank;
            st_next.b_we = st_reg.bank;
            st_next.a_addr = st_reg.bank ? raddr : waddr;
            st_next.b_addr = st_reg.bank ? waddr : raddr;
            if (mode == FBM_BYP)
                st_next.a_wd = pin;
            else
                st_next.a_wd = fbm_pack(fbm_cmul(
                    fbm_unpack(pin, exp_adj, 1'b0), tw, te));
            st_next.b_wd = st_next.a_wd;
            st_next.addr = st_reg.addr + 9'h1;
            if (st_reg.addr == `FBM_ADDR_LAST)
            begin
                st_next.bank = ~st_reg.bank;
                st_next.filled = 1'b1;
            end
            st_next.rd_pend = st_reg.filled;
            st_next.rd_sel = st_reg.bank;
            // one point leaves per point read
            if (st_reg.rd_pend && mode == FBM_BYP)
            begin
                st_next.dout = rd_word;
                st_next.dval = 1'b1;
            end
            else if (st_reg.rd_pend)
            begin
                if (st_reg.hold_ok)
                begin
                    sum = '0;
                    for (int n = 0; n < 4; n++)
                        if (2'(n) <= last)
                        begin
                            pt = fbm_rot({st_reg.h_re[n], st_reg.h_im[n]},
                                (mode == FBM_R4) ? 2'(n * st_reg.ocnt)
                                                 : 2'(2 * n * st_reg.ocnt));
                            sum = {fbm_add(sum[63:32], pt[63:32]),
                                   fbm_add(sum[31:0], pt[31:0])};
                        end
                    st_next.dout = fbm_pack(sum);
                    st_next.dval = 1'b1;
                    st_next.ocnt = st_reg.ocnt + 2'd1;
                    if (st_reg.ocnt >= last)
                        st_next.hold_ok = 1'b0;
                end
                pt = fbm_unpack(rd_word, 2'b00, 1'b0);
                st_next.g_re[st_reg.gcnt] = pt[63:32];
                st_next.g_im[st_reg.gcnt] = pt[31:0];
                st_next.gcnt = st_reg.gcnt + 2'd1;
                if (st_reg.gcnt >= last)
                begin
                    st_next.h_re = st_next.g_re;
                    st_next.h_im = st_next.g_im;
                    st_next.hold_ok = 1'b1;
                    st_next.ocnt = 2'd0;
                    st_next.gcnt = 2'd0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign ram_a_addr = st_reg.a_addr;
    assign ram_a_we = st_reg.a_we;
    assign ram_a_wdata = st_reg.a_wd;
    assign ram_b_addr = st_reg.b_addr;
    assign ram_b_we = st_reg.b_we;
    assign ram_b_wdata = st_reg.b_wd;
    assign data_out = st_reg.dout;
    assign data_valid_out = st_reg.dval;

    fbm_osc u_osc (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ser_in(osc_ser_in),
        .shift_en(osc_shift),
        .load(osc_load),
        .clk_en(osc_clk_en & ~mac),
        .store(osc_store),
        .rewind(osc_rewind),
        .carry_in(osc_carry_in),
        .phase_out(osc_phase),
        .carry_out(osc_carry_out),
        .ser_out(osc_ser_out)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_bank_split: assert property (
        !mac && !$past(mac) && $past(arst_n) |-> ram_a_we != ram_b_we)
        else $error("both banks in the same direction");
    a_mac_alternate: assert property (
        mac && $past(mac) && ram_a_we |=> !ram_a_we && !ram_b_we)
        else $error("two accumulator writes back to back");
    a_sum_same_addr: assert property (
        mac && $past(mac) && ram_a_we |-> ram_a_addr == $past(ram_a_addr))
        else $error("write-back address differs from read");
    a_acc_exp_range: assert property (
        mac && ram_b_we |-> $signed(ram_b_wdata[17:12]) >= -6
                          && $signed(ram_b_wdata[17:12]) <= 8)
        else $error("accumulator exponent out of range");
    a_out_exp_max: assert property (
        data_valid_out |-> data_out[`FBM_D_EX_LSB +: 4] <= 4'(`FBM_EXP_MAX))
        else $error("output exponent above twelve");
    a_bypass_pass: assert property (
        mode == FBM_BYP && st_reg.rd_pend |=> data_valid_out
        && data_out == $past(st_reg.rd_sel ? ram_a_rdata : ram_b_rdata))
        else $error("bypass point altered");
    a_r4_serial: assert property (
        mode == FBM_R4 && $past(mode) == FBM_R4 && st_reg.hold_ok
        && st_reg.rd_pend |=> st_reg.ocnt == $past(st_reg.ocnt) + 2'd1)
        else $error("radix 4 output order broken");
    a_stream_rate: assert property (
        !mac && mode != FBM_BYP && st_reg.rd_pend && st_reg.hold_ok
        |=> data_valid_out)
        else $error("butterfly output missed a cycle");
    a_int_addr_step: assert property (
        !mac && $past(!mac) && !ext_addr_sel && $past(!ext_addr_sel)
        && ram_a_we && $past(ram_a_we) |-> ram_a_addr == $past(ram_a_addr)
        + 9'h1)
        else $error("internal write address skipped");

    c_bypass: cover property (mode == FBM_BYP && data_valid_out);
    c_r4_group: cover property (mode == FBM_R4 && st_reg.ocnt == 2'd3
                                && data_valid_out);
    c_mac_write: cover property (mode == FBM_MACNP && ram_a_we);
    c_pol_write: cover property (mode == FBM_MACPOL && ram_a_we);

endmodule : fbm_core

// File: fbm_defs.svh
// Purpose: Constants of the butterfly and accumulate datapath.
// Assumes: Included by every design file that needs a width or a field.
// Notes: Fixed point words carry FBM_FB fraction bits.
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH

`define FBM_CLK_MHZ 40
`define FBM_FIX_W 32
`define FBM_FB 20
`define FBM_D_MAG_W 6
`define FBM_D_SH 14
`define FBM_D_RE_LSB 0
`define FBM_D_IM_LSB 7
`define FBM_D_EX_LSB 14
`define FBM_D_W 18
`define FBM_EXP_MAX 12
`define FBM_TRUNC_MASK 6'h38
`define FBM_A_RE_LSB 0
`define FBM_A_IM_LSB 15
`define FBM_A_EX_LSB 30
`define FBM_A_W 36
`define FBM_A_MAG_MAX 14'h3fff
`define FBM_A_SH 6
`define FBM_A_SH_MAX 14
`define FBM_RAM_AW 9
`define FBM_ADDR_LAST 9'h1ff
`define FBM_OSC_W 10

`endif

// File: fbm_pkg.sv
// Purpose: Types shared by the butterfly datapath and its oscillator.
// Assumes: Constants come from fbm_defs.svh.
// Notes: R4, R2 and bypass codes are also the external mode select encoding; accumulate comes from the enable pins.
package fbm_pkg;

    typedef enum logic [2:0]
    {
        FBM_R4 = 3'b000,
        FBM_R2 = 3'b001,
        FBM_BYP = 3'b010,
        FBM_MACNP = 3'b011,
        FBM_MACPOL = 3'b100
    } fbm_mode_t;

    typedef enum logic
    {
        FBM_PH_OPER = 1'b0,
        FBM_PH_SUM = 1'b1
    } fbm_ph_t;

endpackage : fbm_pkg

// File: fbm_osc.sv
// Purpose: Ten bit oscillator slice with serial holding registers.
// Assumes: Runs on the datapath clock; clk_en paces the accumulator.
// Notes: Load beats rewind, rewind beats an accumulator step.
`timescale 1ns/10ps
`include "fbm_defs.svh"

module fbm_osc
    import fbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ser_in,
    input wire logic shift_en,
    input wire logic load,
    input wire logic clk_en,
    input wire logic store,
    input wire logic rewind,
    input wire logic carry_in,
    output logic [`FBM_OSC_W-1:0] phase_out,
    output logic carry_out,
    output logic ser_out
);

    typedef struct packed {
        logic [`FBM_OSC_W-1:0] hold_ph;
        logic [`FBM_OSC_W-1:0] hold_inc;
        logic [`FBM_OSC_W-1:0] act_inc;
        logic [`FBM_OSC_W-1:0] acc;
        logic [`FBM_OSC_W-1:0] saved;
        logic carry;
    } fbm_osc_st_t;

    fbm_osc_st_t st_reg;
    fbm_osc_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (shift_en)
        begin
            st_next.hold_ph = {ser_in, st_reg.hold_ph[`FBM_OSC_W-1:1]};
            st_next.hold_inc = {st_reg.hold_ph[0],
                                st_reg.hold_inc[`FBM_OSC_W-1:1]};
        end
        st_next.carry = 1'b0;
        if (store)
        begin
            st_next.saved = st_reg.acc;
        end
        if (load)
        begin
            st_next.acc = st_reg.hold_ph;
            st_next.act_inc = st_reg.hold_inc;
        end
        else if (rewind)
        begin
            st_next.acc = st_reg.saved;
        end
        else if (clk_en)
        begin
            {st_next.carry, st_next.acc} = {1'b0, st_reg.acc}
                + {1'b0, st_reg.act_inc} + {{`FBM_OSC_W{1'b0}}, carry_in};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign phase_out = st_reg.acc;
    assign carry_out = st_reg.carry;
    assign ser_out = st_reg.hold_inc[0];

    a_osc_rewind: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rewind && !load |=> phase_out == $past(st_reg.saved))
        else $error("rewind did not restore the saved phase");

endmodule : fbm_osc

// File: fbm_ram_model.sv
// Purpose: One 512 by 18 external RAM bank.
// Assumes: Read is combinational on the address.
// Notes: A write lands at the rising edge.
`timescale 1ns/10ps
`include "fbm_defs.svh"
module fbm_ram_model
(
    input wire logic clk,
    input wire logic [`FBM_RAM_AW-1:0] addr,
    input wire logic we,
    input wire logic [`FBM_D_W-1:0] wdata,
    output logic [`FBM_D_W-1:0] rdata
);
    logic [`FBM_D_W-1:0] mem [0:511];
    assign rdata = mem[addr];
    always_ff @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
    end
endmodule : fbm_ram_model

// File: fbm_core_tb.sv
// Purpose: Self-checking bench of the butterfly datapath.
// Assumes: Inputs change at the falling edge.
// Notes: Values are compared scaled by two to the 22.
`timescale 1ns/10ps
`include "fbm_defs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module fbm_core_tb
    import fbm_pkg::*;
;
    logic sys_clk = 0, arst_n = 0, pol_mode = 0, stage0 = 0, aux_sel = 0;
    logic osc_sine_in_pin = 0, osc_cosine_in_pin = 0, osc_carry_in = 0;
    logic osc_output_enable_pin = 0, coeff_output_enable_pin = 0;
    logic ext_addr_sel = 0, acc_clear = 0, osc_ser_in = 0, osc_shift = 0;
    logic osc_load = 0, osc_clk_en = 0, osc_store = 0, osc_rewind = 0;
    fbm_mode_t fft_mode = FBM_BYP;
    logic [1:0] exp_adj = 0;
    logic [9:0] twid_in = 10'h008, osc_phase;
    logic [8:0] ext_wr_addr = 9'h005, ext_rd_addr = 0, ram_a_addr, ram_b_addr;
    logic [17:0] data_in = 18'h08860, aux_in = 0, ram_a_rdata, ram_b_rdata;
    logic [17:0] ram_a_wdata, ram_b_wdata, data_out;
    logic ram_a_we, ram_b_we, data_valid_out, osc_carry_out, osc_ser_out;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    fbm_core u_fbm_core (.sys_clk, .arst_n, .fft_mode, .pol_mode, .stage0,
        .exp_adj, .aux_sel, .data_in, .aux_in, .twid_in, .osc_sine_in_pin,
        .osc_cosine_in_pin, .osc_output_enable_pin, .coeff_output_enable_pin,
        .ext_addr_sel, .ext_wr_addr, .ext_rd_addr, .acc_clear, .ram_a_addr,
        .ram_a_we, .ram_a_wdata, .ram_a_rdata, .ram_b_addr, .ram_b_we,
        .ram_b_wdata, .ram_b_rdata, .data_out, .data_valid_out, .osc_ser_in,
        .osc_shift, .osc_load, .osc_clk_en, .osc_store, .osc_rewind,
        .osc_carry_in, .osc_phase, .osc_carry_out, .osc_ser_out);
    fbm_ram_model u_fbm_ram_model (.clk(sys_clk), .addr(ram_a_addr),
        .we(ram_a_we), .wdata(ram_a_wdata), .rdata(ram_a_rdata));
    fbm_ram_model u_fbm_ram_model_b (.clk(sys_clk), .addr(ram_b_addr),
        .we(ram_b_we), .wdata(ram_b_wdata), .rdata(ram_b_rdata));
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    // Signed mantissa of one half of a data word, shifted by its exponent.
    function automatic logic signed [31:0] dec(input logic [17:0] w,
                                               input logic im);
        logic [6:0] m;
        m = im ? w[13:7] : w[6:0];
        dec = 32'(m[5:0]) << (16 - w[17:14]);
        if (m[6])
            dec = -dec;
    endfunction : dec
    function automatic logic signed [31:0] acc_re(input logic [35:0] w);
        acc_re = w[14] ? -32'(~w[13:0]) : 32'(w[13:0]);
        acc_re = acc_re <<< (8 + $signed(w[35:30]));
    endfunction : acc_re
    task automatic t_bypass();
        tick(1);
        `CHK("wea", 1'b1, ram_a_we)
        `CHK("re", -(32'sd1 << 19), dec(ram_a_wdata, 0))
        `CHK("im", 32'sd1 << 18, dec(ram_a_wdata, 1))
        for (int n = 0; n < 600 && data_valid_out !== 1'b1; n++)
            tick(1);
        `CHK("byp", -(32'sd1 << 19), dec(data_out, 0))
    endtask : t_bypass
    task automatic t_adj();
        fft_mode = FBM_R4;
        aux_sel = 1;
        aux_in = data_in;
        data_in = 0;
        for (int a = 0; a < 4; a++)
        begin
            exp_adj = 2'(a);
            tick(1);
            `CHK("adj", -(32'sd1 << (18 + (a > 2 ? 2 : a))),
                 dec(ram_a_we ? ram_a_wdata : ram_b_wdata, 0))
        end
        {stage0, twid_in} = {1'b1, 10'h028};
        tick(1);
        `CHK("x0", 18'h00860, data_out)
        `CHK("win", -(32'sd1 << 19), dec(ram_a_we ? ram_a_wdata : ram_b_wdata, 0))
        stage0 = 0;
    endtask : t_adj
    task automatic t_mac(input logic pol);
        logic signed [31:0] sum;
        sum = 0;
        {pol_mode, aux_sel, exp_adj, ext_addr_sel, acc_clear} = {pol, 5'h07};
        {data_in, twid_in} = {18'h00020, 10'h004};
        {osc_output_enable_pin, coeff_output_enable_pin, arst_n} = 3'h6;
        tick(1);
        arst_n = 1;
        repeat (3)
        begin
            for (int n = 0; n < 8 && ram_a_we !== 1'b1; n++)
                tick(1);
            acc_clear = 0;
            sum += pol ? 32'sd1 << 21 : 32'sd1 << 20;
            `CHK("acc", sum, acc_re({ram_b_wdata, ram_a_wdata}))
            `CHK("web", 1'b1, ram_b_we)
            `CHK("adr", 9'h005, ram_a_addr)
            tick(1);
            `CHK("rd", 1'b0, ram_a_we)
        end
    endtask : t_mac
    task automatic t_osc();
        logic [19:0] s;
        s = {10'h3fe, 10'h001};
        {osc_output_enable_pin, coeff_output_enable_pin, osc_shift} = 3'h1;
        for (int i = 0; i < 20; i++)
        begin
            osc_ser_in = s[i];
            tick(1);
        end
        {osc_shift, osc_load} = 2'h1;
        tick(1);
        {osc_load, osc_clk_en} = 2'h1;
        `CHK("ld", 10'h3fe, osc_phase)
        `CHK("so", 1'b1, osc_ser_out)
        tick(2);
        `CHK("wrap", 10'h000, osc_phase)
        `CHK("cy", 1'b1, osc_carry_out)
        {osc_clk_en, osc_store} = 2'h1;
        tick(1);
        {osc_clk_en, osc_store, osc_carry_in} = 3'h5;
        tick(3);
        `CHK("run", 10'h006, osc_phase)
        {osc_clk_en, osc_rewind} = 2'h1;
        tick(1);
        `CHK("rew", 10'h000, osc_phase)
    endtask : t_osc
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        tick(5);
        `CHK("we0", 1'b0, ram_a_we)
        `CHK("dv0", 1'b0, data_valid_out)
        arst_n = 1;
        t_bypass();
        t_adj();
        t_mac(0);
        t_mac(1);
        t_osc();
        final_report();
    end
endmodule : fbm_core_tb
